// ---- hdl/hcmd_pkg.sv ----
// constants, codes and register map for the host command block
// Summary of operation
// - copy test code a2; arguments are byte count, source address, destination address.
// - copy reads one unit from source, then writes it to destination, until count bytes are moved.
// - copy data passes through the host data register, never the queues.
// - link keeps running but its DMA service is held during copy.
// - semaphore goes to ff when copy ends; no pass/fail is reported.
// - dump writes registers into a 650-byte area, then semaphore ff.
// - dump image uses fixed displacements, e.g. 114 and 118 for pointers.
// - word f4 holds acknowledge variable or filter mask word two.
// - off-line code 44 disables transmit, receive, timeouts; semaphore ff after.
// - off-line in bus error state acknowledges the error.
// - on-line code 45 enables receive and transmit; semaphore ff after.
// - reload code 46 refreshes parameters; semaphore ff at acceptance.
// - reloaded parameters take effect only at their next use.
// - new pad time applies when the next frame transmission starts.
// - new nonstandard control applies at next nonstandard frame.
// - new idle timer value applies at next timer start or restart.
// - dump command has its own code, 20.
// - semaphore goes fe on any command, ff after completion or acceptance.
// - test commands run on-line or off-line; ignored in bus error state.
package hcmd_pkg;
	localparam logic [7:0]  OP_COPY     = 8'ha2;
	localparam logic [7:0]  OP_DUMP     = 8'h20;
	localparam logic [7:0]  OP_OFFLINE  = 8'h44;
	localparam logic [7:0]  OP_ONLINE   = 8'h45;
	localparam logic [7:0]  OP_RELOAD   = 8'h46;
	localparam logic [7:0]  SEM_BUSY    = 8'hfe;
	localparam logic [7:0]  SEM_READY   = 8'hff;
	localparam logic [7:0]  REG_CMD     = 8'h00;
	localparam logic [7:0]  REG_SEM     = 8'h04;
	localparam logic [7:0]  REG_DATA    = 8'h08;
	localparam logic [7:0]  REG_GCB     = 8'h0c;
	localparam logic [7:0]  REG_CFG     = 8'h10;
	localparam logic [7:0]  REG_STAT    = 8'h14;
	localparam logic [7:0]  REG_TXNEXT  = 8'h18;
	localparam logic [7:0]  REG_TXLLT   = 8'h1c;
	localparam int          CFG_BUS16   = 0;
	localparam int          ST_ONLINE   = 0;
	localparam int          ST_BUSERR   = 1;
	localparam int          ST_BUSY     = 2;
	localparam int          ST_DMAHOLD  = 3;
	localparam logic [31:0] GCB_ARG1    = 32'h0000_0010;
	localparam logic [31:0] GCB_RELOAD  = 32'h0000_0040;
	localparam logic [6:0]  ARGS_COPY   = 7'd12;
	localparam logic [6:0]  ARGS_DUMP   = 7'd8;
	localparam logic [6:0]  RELOAD_LEN  = 7'd5;
	localparam logic [15:0] DUMP_LEN    = 16'd650;
	localparam logic [15:0] DISP_RXK    = 16'h00f2;
	localparam logic [15:0] DISP_SHARED = 16'h00f4;
	localparam logic [15:0] DISP_NONSTD = 16'h00fc;
	localparam logic [15:0] DISP_REV    = 16'h00fe;
	localparam logic [15:0] DISP_TXNEXT = 16'h0114;
	localparam logic [15:0] DISP_TXLLT  = 16'h0118;
	localparam logic [1:0]  RESP_OKAY   = 2'h0;
	localparam logic [1:0]  RESP_SLVERR = 2'h2;
	typedef enum {HC_IDLE, HC_FETCH, HC_COPY_RD, HC_COPY_WR, HC_DUMP_WR} hcmd_state_t;
endpackage

// ---- hdl/hcmd_axil_slave.sv ----
// axi4-lite slave handshake for the command block registers
`timescale 1ns/1ps
module hcmd_axil_slave import hcmd_pkg::*; #(
	parameter int AW = 8
) (
	input  wire logic          clk,
	input  wire logic          rst,
	input  wire logic [AW-1:0] s_axi_awaddr,
	input  wire logic          s_axi_awvalid,
	output logic               s_axi_awready,
	input  wire logic [31:0]   s_axi_wdata,
	input  wire logic [3:0]    s_axi_wstrb,
	input  wire logic          s_axi_wvalid,
	output logic               s_axi_wready,
	output logic [1:0]         s_axi_bresp,
	output logic               s_axi_bvalid,
	input  wire logic          s_axi_bready,
	input  wire logic          s_axi_arvalid,
	output logic               s_axi_arready,
	output logic [31:0]        s_axi_rdata,
	output logic [1:0]         s_axi_rresp,
	output logic               s_axi_rvalid,
	input  wire logic          s_axi_rready,
	input  wire logic          wr_ok,
	input  wire logic          rd_ok,
	input  wire logic [31:0]   rd_data,
	output logic               wr_en,
	output logic [AW-1:0]      wr_addr,
	output logic [31:0]        wr_data,
	output logic [3:0]         wr_strb
);
	logic aw_full_ff;
	logic w_full_ff;
	logic bvalid_ff;
	logic rvalid_ff;
	logic [1:0] bresp_ff;
	logic [1:0] rresp_ff;
	logic [31:0] rdata_ff;

	// address and data are taken in either order; response waits for both
	assign s_axi_awready = !aw_full_ff && !bvalid_ff;
	assign s_axi_wready  = !w_full_ff && !bvalid_ff;
	assign wr_en         = aw_full_ff && w_full_ff && !bvalid_ff;
	assign s_axi_bvalid  = bvalid_ff;
	assign s_axi_bresp   = bresp_ff;
	assign s_axi_arready = !rvalid_ff;
	assign s_axi_rvalid  = rvalid_ff;
	assign s_axi_rresp   = rresp_ff;
	assign s_axi_rdata   = rdata_ff;

	always_ff @(posedge clk) begin
		if (rst) begin
			aw_full_ff <= 1'b0;
			wr_addr    <= '0;
		end else if (s_axi_awvalid && s_axi_awready) begin
			aw_full_ff <= 1'b1;
			wr_addr    <= s_axi_awaddr;
		end else if (wr_en) begin
			aw_full_ff <= 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			w_full_ff <= 1'b0;
			wr_data   <= '0;
			wr_strb   <= '0;
		end else if (s_axi_wvalid && s_axi_wready) begin
			w_full_ff <= 1'b1;
			wr_data   <= s_axi_wdata;
			wr_strb   <= s_axi_wstrb;
		end else if (wr_en) begin
			w_full_ff <= 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			bvalid_ff <= 1'b0;
			bresp_ff  <= RESP_OKAY;
		end else if (wr_en) begin
			bvalid_ff <= 1'b1;
			bresp_ff  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_bready) begin
			bvalid_ff <= 1'b0;
		end
	end

	// read data is sampled at the address handshake
	always_ff @(posedge clk) begin
		if (rst) begin
			rvalid_ff <= 1'b0;
			rresp_ff  <= RESP_OKAY;
			rdata_ff  <= '0;
		end else if (s_axi_arvalid && s_axi_arready) begin
			rvalid_ff <= 1'b1;
			rresp_ff  <= rd_ok ? RESP_OKAY : RESP_SLVERR;
			rdata_ff  <= rd_ok ? rd_data : '0;
		end else if (s_axi_rready) begin
			rvalid_ff <= 1'b0;
		end
	end
endmodule

// ---- hdl/hcmd_reload_shadow.sv ----
// reloadable parameter: new value waits until the parameter is next used
`timescale 1ns/1ps
module hcmd_reload_shadow #(
	parameter int W = 16
) (
	input  wire logic         clk,
	input  wire logic         rst,
	input  wire logic         load,
	input  wire logic [W-1:0] load_val,
	input  wire logic         use_evt,
	output logic [W-1:0]      value
);
	logic         pend_ff;
	logic [W-1:0] pend_val_ff;

	// a load in the same cycle as a use is kept for the following use
	always_ff @(posedge clk) begin
		if (rst) begin
			pend_ff     <= 1'b0;
			pend_val_ff <= '0;
		end else if (load) begin
			pend_ff     <= 1'b1;
			pend_val_ff <= load_val;
		end else if (use_evt) begin
			pend_ff     <= 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			value <= '0;
		end else if (use_evt && pend_ff) begin
			value <= pend_val_ff;
		end
	end
endmodule

// ---- hdl/hcmd_core.sv ----
// host test and state command interpreter with dma master port
`timescale 1ns/1ps
module hcmd_core import hcmd_pkg::*; #(
	parameter int          AW       = 8,
	parameter logic [15:0] REVISION = 16'h0001 // arbitrary value
) (
	input  wire logic          clk,
	input  wire logic          rst,
	input  wire logic [AW-1:0] s_axi_awaddr,
	input  wire logic [2:0]    s_axi_awprot,
	input  wire logic          s_axi_awvalid,
	output logic               s_axi_awready,
	input  wire logic [31:0]   s_axi_wdata,
	input  wire logic [3:0]    s_axi_wstrb,
	input  wire logic          s_axi_wvalid,
	output logic               s_axi_wready,
	output logic [1:0]         s_axi_bresp,
	output logic               s_axi_bvalid,
	input  wire logic          s_axi_bready,
	input  wire logic [AW-1:0] s_axi_araddr,
	input  wire logic [2:0]    s_axi_arprot,
	input  wire logic          s_axi_arvalid,
	output logic               s_axi_arready,
	output logic [31:0]        s_axi_rdata,
	output logic [1:0]         s_axi_rresp,
	output logic               s_axi_rvalid,
	input  wire logic          s_axi_rready,
	output logic               mem_req,
	output logic               mem_we,
	output logic [31:0]        mem_addr,
	output logic [15:0]        mem_wdata,
	output logic [1:0]         mem_be,
	input  wire logic          mem_ack,
	input  wire logic [15:0]   mem_rdata,
	input  wire logic          bus_error,
	input  wire logic          filter_mode,
	input  wire logic [15:0]   rx_k_or_mask1,
	input  wire logic [15:0]   rx_ack_var,
	input  wire logic [15:0]   filter_mask_w2,
	input  wire logic          tx_frame_start,
	input  wire logic          nonstd_frame_evt,
	input  wire logic          idle_timer_start,
	output logic               tx_enable,
	output logic               rx_enable,
	output logic               timeout_enable,
	output logic               link_dma_hold,
	output logic [7:0]         pad_time_sel,
	output logic [15:0]        nonstd_ctrl,
	output logic [15:0]        idle_link_timer
);
	hcmd_state_t  state_ff;
	logic         wr_en;
	logic [AW-1:0] wr_addr;
	logic [31:0]  wr_data;
	logic [3:0]   wr_strb;
	logic         wr_ok;
	logic         rd_ok;
	logic [31:0]  rd_data;
	logic [7:0]   semaphore_reg;
	logic [7:0]   command_reg;
	logic         go_ff;
	logic [31:0]  host_data_reg;
	logic [31:0]  gcb_ptr_ff;
	logic         bus16_ff;
	logic         online_ff;
	logic         bus_err_ff;
	logic [31:0]  tx_next_ptr_ff;
	logic [31:0]  tx_link_table_ptr;
	logic [31:0]  fetch_addr_ff;
	logic [6:0]   fetch_left_ff;
	logic [95:0]  fetch_sh_ff;
	logic [95:0]  fetch_nxt;
	logic [31:0]  len_ff;
	logic [31:0]  src_ff;
	logic [31:0]  dst_ff;
	logic [1:0]   cur_n_ff;
	logic [31:0]  dump_base_ff;
	logic [15:0]  disp_ff;
	logic         reload_load;
	logic [1:0]   unit_n;
	logic [7:0]   rd_byte;
	logic [31:0]  dump_addr;
	logic [15:0]  dump_hw;
	logic         cmd_hit;

	// one unit per access: halfword on a 16-bit bus when aligned and two bytes remain
	function automatic logic [1:0] unit_size(input logic b16, input logic a0,
		input logic [31:0] left);
		unit_size = (b16 && !a0 && left > 32'd1) ? 2'd2 : 2'd1;
	endfunction

	function automatic logic [31:0] merge32(input logic [31:0] old, input logic [31:0] nv,
		input logic [3:0] be);
		for (int i = 0; i < 4; i++) begin
			merge32[i*8 +: 8] = be[i] ? nv[i*8 +: 8] : old[i*8 +: 8];
		end
	endfunction

	// dump image byte at a displacement, high byte at the even address
	function automatic logic [7:0] dump_byte(input logic [15:0] d, input logic [31:0] nxt,
		input logic [31:0] llt, input logic [15:0] rxk, input logic [15:0] shw,
		input logic [15:0] nsc);
		logic [15:0] hw;
		hw = 16'h0000;
		dump_byte = 8'h00;
		if (d[15:1] == DISP_RXK[15:1]) hw = rxk;
		if (d[15:1] == DISP_SHARED[15:1]) hw = shw;
		if (d[15:1] == DISP_NONSTD[15:1]) hw = nsc;
		if (d[15:1] == DISP_REV[15:1]) hw = REVISION;
		dump_byte = d[0] ? hw[7:0] : hw[15:8];
		if (d[15:2] == DISP_TXNEXT[15:2]) dump_byte = nxt[(3 - d[1:0]) * 8 +: 8];
		if (d[15:2] == DISP_TXLLT[15:2]) dump_byte = llt[(3 - d[1:0]) * 8 +: 8];
	endfunction

	hcmd_axil_slave #(.AW(AW)) u_axil (
		.clk           (clk),
		.rst           (rst),
		.s_axi_awaddr  (s_axi_awaddr),
		.s_axi_awvalid (s_axi_awvalid),
		.s_axi_awready (s_axi_awready),
		.s_axi_wdata   (s_axi_wdata),
		.s_axi_wstrb   (s_axi_wstrb),
		.s_axi_wvalid  (s_axi_wvalid),
		.s_axi_wready  (s_axi_wready),
		.s_axi_bresp   (s_axi_bresp),
		.s_axi_bvalid  (s_axi_bvalid),
		.s_axi_bready  (s_axi_bready),
		.s_axi_arvalid (s_axi_arvalid),
		.s_axi_arready (s_axi_arready),
		.s_axi_rdata   (s_axi_rdata),
		.s_axi_rresp   (s_axi_rresp),
		.s_axi_rvalid  (s_axi_rvalid),
		.s_axi_rready  (s_axi_rready),
		.wr_ok         (wr_ok),
		.rd_ok         (rd_ok),
		.rd_data       (rd_data),
		.wr_en         (wr_en),
		.wr_addr       (wr_addr),
		.wr_data       (wr_data),
		.wr_strb       (wr_strb)
	);

	always_comb begin
		wr_ok = 1'b1;
		unique case (wr_addr[7:0])
			REG_CMD, REG_DATA, REG_GCB, REG_CFG, REG_TXNEXT, REG_TXLLT: wr_ok = 1'b1;
			default: wr_ok = 1'b0;
		endcase
	end

	always_comb begin
		rd_ok   = 1'b1;
		rd_data = 32'h0000_0000;
		unique case (s_axi_araddr[7:0])
			REG_CMD:    rd_data = {24'h000000, command_reg};
			REG_SEM:    rd_data = {24'h000000, semaphore_reg};
			REG_DATA:   rd_data = host_data_reg;
			REG_GCB:    rd_data = gcb_ptr_ff;
			REG_CFG:    rd_data = {31'h0, bus16_ff};
			REG_STAT:   rd_data = {28'h0, link_dma_hold, state_ff != HC_IDLE,
				bus_err_ff, online_ff};
			REG_TXNEXT: rd_data = tx_next_ptr_ff;
			REG_TXLLT:  rd_data = tx_link_table_ptr;
			default:    rd_ok   = 1'b0;
		endcase
	end

	// commands written while one is in progress are dropped
	assign cmd_hit = wr_en && wr_addr[7:0] == REG_CMD && wr_strb[0]
		&& state_ff == HC_IDLE && !go_ff;

	always_ff @(posedge clk) begin
		if (rst) begin
			command_reg <= 8'h00;
			go_ff       <= 1'b0;
		end else begin
			go_ff <= cmd_hit;
			if (cmd_hit) command_reg <= wr_data[7:0];
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			gcb_ptr_ff        <= '0;
			bus16_ff          <= 1'b0;
			tx_next_ptr_ff    <= '0;
			tx_link_table_ptr <= '0;
		end else if (wr_en) begin
			if (wr_addr[7:0] == REG_GCB) gcb_ptr_ff <= merge32(gcb_ptr_ff, wr_data, wr_strb);
			if (wr_addr[7:0] == REG_CFG && wr_strb[0]) bus16_ff <= wr_data[CFG_BUS16];
			if (wr_addr[7:0] == REG_TXNEXT)
				tx_next_ptr_ff <= merge32(tx_next_ptr_ff, wr_data, wr_strb);
			if (wr_addr[7:0] == REG_TXLLT)
				tx_link_table_ptr <= merge32(tx_link_table_ptr, wr_data, wr_strb);
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			semaphore_reg <= SEM_READY;
		end else if (cmd_hit) begin
			semaphore_reg <= SEM_BUSY;
		end else if (go_ff) begin
			if ((command_reg == OP_COPY || command_reg == OP_DUMP) && !bus_err_ff)
				semaphore_reg <= SEM_BUSY;
			else
				semaphore_reg <= SEM_READY;
		end else if (state_ff == HC_FETCH && mem_ack && fetch_left_ff == {5'h0, unit_n}
			&& command_reg == OP_COPY && fetch_nxt[95:64] == 32'h0) begin
			semaphore_reg <= SEM_READY;
		end else if (state_ff == HC_COPY_WR && mem_ack && len_ff == {30'h0, cur_n_ff}) begin
			semaphore_reg <= SEM_READY;
		end else if (state_ff == HC_DUMP_WR && mem_ack && disp_ff + {14'h0, unit_n} == DUMP_LEN) begin
			semaphore_reg <= SEM_READY;
		end
	end

	// error from the bus wins over the acknowledge in the same cycle
	always_ff @(posedge clk) begin
		if (rst) begin
			online_ff  <= 1'b0;
			bus_err_ff <= 1'b0;
		end else begin
			if (go_ff && command_reg == OP_OFFLINE) begin
				online_ff  <= 1'b0;
				bus_err_ff <= 1'b0;
			end
			if (go_ff && command_reg == OP_ONLINE) online_ff <= 1'b1;
			if (bus_error) bus_err_ff <= 1'b1;
		end
	end

	assign tx_enable      = online_ff && !bus_err_ff;
	assign rx_enable      = online_ff && !bus_err_ff;
	assign timeout_enable = online_ff && !bus_err_ff;
	// link dma is starved for the whole copy; long counts stall the link
	assign link_dma_hold  = state_ff == HC_COPY_RD || state_ff == HC_COPY_WR
		|| (state_ff == HC_FETCH && command_reg == OP_COPY);

	assign dump_addr = dump_base_ff + {16'h0, disp_ff};
	assign dump_hw   = {dump_byte(disp_ff, tx_next_ptr_ff, tx_link_table_ptr, rx_k_or_mask1,
		filter_mode ? filter_mask_w2 : rx_ack_var, nonstd_ctrl),
		dump_byte(disp_ff + 16'd1, tx_next_ptr_ff, tx_link_table_ptr, rx_k_or_mask1,
		filter_mode ? filter_mask_w2 : rx_ack_var, nonstd_ctrl)};

	always_comb begin
		unit_n = 2'd1;
		unique case (state_ff)
			HC_IDLE:    unit_n = 2'd1;
			HC_FETCH:   unit_n = unit_size(bus16_ff, fetch_addr_ff[0], {25'h0, fetch_left_ff});
			HC_COPY_RD: unit_n = unit_size(bus16_ff, src_ff[0], len_ff);
			HC_COPY_WR: unit_n = cur_n_ff;
			HC_DUMP_WR: unit_n = unit_size(bus16_ff, dump_addr[0], {16'h0, DUMP_LEN - disp_ff});
		endcase
	end

	always_comb begin
		mem_req   = state_ff != HC_IDLE;
		mem_we    = state_ff == HC_COPY_WR || state_ff == HC_DUMP_WR;
		mem_addr  = fetch_addr_ff;
		mem_wdata = 16'h0000;
		mem_be    = 2'b00;
		unique case (state_ff)
			HC_IDLE, HC_FETCH: mem_addr = fetch_addr_ff;
			HC_COPY_RD:        mem_addr = src_ff;
			HC_COPY_WR:        mem_addr = dst_ff;
			HC_DUMP_WR:        mem_addr = dump_addr;
		endcase
		if (state_ff == HC_COPY_WR)
			mem_wdata = unit_n == 2'd2 ? host_data_reg[15:0] : {2{host_data_reg[7:0]}};
		if (state_ff == HC_DUMP_WR)
			mem_wdata = unit_n == 2'd2 ? dump_hw : {2{dump_hw[15:8]}};
		if (unit_n == 2'd2) mem_be = 2'b11;
		else if (bus16_ff && !mem_addr[0]) mem_be = 2'b10;
		else mem_be = 2'b01;
	end

	// an 8-bit bus and odd addresses on a 16-bit bus return the byte in the low lane
	assign rd_byte = (bus16_ff && !mem_addr[0]) ? mem_rdata[15:8] : mem_rdata[7:0];

	// argument shifter with the unit now being acknowledged; last bytes land in the low end
	assign fetch_nxt = unit_n == 2'd2 ? {fetch_sh_ff[79:0], mem_rdata}
		: {fetch_sh_ff[87:0], rd_byte};

	assign reload_load = state_ff == HC_FETCH && mem_ack && command_reg == OP_RELOAD
		&& fetch_left_ff == {5'h0, unit_n};

	always_ff @(posedge clk) begin
		if (rst) begin
			state_ff      <= HC_IDLE;
			fetch_addr_ff <= '0;
			fetch_left_ff <= '0;
			fetch_sh_ff   <= '0;
			len_ff        <= '0;
			src_ff        <= '0;
			dst_ff        <= '0;
			cur_n_ff      <= 2'd1;
			dump_base_ff  <= '0;
			disp_ff       <= '0;
			host_data_reg <= '0;
		end else begin
			if (wr_en && wr_addr[7:0] == REG_DATA && state_ff == HC_IDLE)
				host_data_reg <= merge32(host_data_reg, wr_data, wr_strb);
			unique case (state_ff)
				HC_IDLE: begin
					if (go_ff && !bus_err_ff && command_reg == OP_COPY) begin
						state_ff      <= HC_FETCH;
						fetch_addr_ff <= gcb_ptr_ff + GCB_ARG1;
						fetch_left_ff <= ARGS_COPY;
					end else if (go_ff && !bus_err_ff && command_reg == OP_DUMP) begin
						state_ff      <= HC_FETCH;
						fetch_addr_ff <= gcb_ptr_ff + GCB_ARG1;
						fetch_left_ff <= ARGS_DUMP;
					end else if (go_ff && command_reg == OP_RELOAD) begin
						state_ff      <= HC_FETCH;
						fetch_addr_ff <= gcb_ptr_ff + GCB_RELOAD;
						fetch_left_ff <= RELOAD_LEN;
					end
				end
				HC_FETCH: begin
					if (mem_ack) begin
						fetch_sh_ff   <= fetch_nxt;
						fetch_addr_ff <= fetch_addr_ff + {30'h0, unit_n};
						fetch_left_ff <= fetch_left_ff - {5'h0, unit_n};
						if (fetch_left_ff == {5'h0, unit_n}) begin
							state_ff <= HC_IDLE;
							if (command_reg == OP_COPY) begin
								len_ff   <= fetch_nxt[95:64];
								src_ff   <= fetch_nxt[63:32];
								dst_ff   <= fetch_nxt[31:0];
								state_ff <= fetch_nxt[95:64] == 32'h0 ? HC_IDLE : HC_COPY_RD;
							end
							if (command_reg == OP_DUMP) begin
								dump_base_ff <= fetch_nxt[31:0];
								disp_ff      <= 16'h0000;
								state_ff     <= HC_DUMP_WR;
							end
						end
					end
				end
				HC_COPY_RD: begin
					if (mem_ack) begin
						host_data_reg <= unit_n == 2'd2 ? {16'h0000, mem_rdata}
							: {24'h000000, rd_byte};
						cur_n_ff      <= unit_n;
						src_ff        <= src_ff + {30'h0, unit_n};
						state_ff      <= HC_COPY_WR;
					end
				end
				HC_COPY_WR: begin
					if (mem_ack) begin
						dst_ff   <= dst_ff + {30'h0, cur_n_ff};
						len_ff   <= len_ff - {30'h0, cur_n_ff};
						state_ff <= len_ff == {30'h0, cur_n_ff} ? HC_IDLE : HC_COPY_RD;
					end
				end
				HC_DUMP_WR: begin
					if (mem_ack) begin
						disp_ff  <= disp_ff + {14'h0, unit_n};
						if (disp_ff + {14'h0, unit_n} == DUMP_LEN) state_ff <= HC_IDLE;
					end
				end
			endcase
		end
	end

	hcmd_reload_shadow #(.W(8)) u_pad (
		.clk      (clk),
		.rst      (rst),
		.load     (reload_load),
		.load_val (fetch_nxt[39:32]),
		.use_evt  (tx_frame_start),
		.value    (pad_time_sel)
	);

	hcmd_reload_shadow #(.W(16)) u_nonstd (
		.clk      (clk),
		.rst      (rst),
		.load     (reload_load),
		.load_val (fetch_nxt[31:16]),
		.use_evt  (nonstd_frame_evt),
		.value    (nonstd_ctrl)
	);

	hcmd_reload_shadow #(.W(16)) u_idle (
		.clk      (clk),
		.rst      (rst),
		.load     (reload_load),
		.load_val (fetch_nxt[15:0]),
		.use_evt  (idle_timer_start),
		.value    (idle_link_timer)
	);
endmodule

// ---- sim/hcmd_mem.sv ----
// shared memory model answering the dma port after lat wait cycles
`timescale 1ns/1ps
module hcmd_mem (
	input  wire logic        clk,
	input  wire logic        req,
	input  wire logic        we,
	input  wire logic [31:0] addr,
	input  wire logic [15:0] wdata,
	input  wire logic [1:0]  be,
	input  wire logic [1:0]  lat,
	output logic             ack,
	output logic [15:0]      rdata
);
	logic [7:0]  m [0:2047];
	logic [1:0]  w_ff = '0;
	logic [10:0] a;
	assign a = addr[10:0];
	initial ack = 1'h0;
	initial rdata = '0;
	always @(posedge clk) begin
		ack <= 1'h0;
		// inverted when idle so stale data never passes for a read
		rdata <= ~rdata;
		if (req && !ack) begin
			w_ff <= w_ff + 2'h1;
			if (w_ff == lat) begin
				w_ff <= '0;
				ack <= 1'h1;
				if (we && be[1]) m[a] <= wdata[15:8];
				if (we && be == 2'h3) m[a + 1] <= wdata[7:0];
				if (we && be == 2'h1) m[a] <= wdata[7:0];
				if (!we) rdata <= {m[a], be == 2'h1 ? m[a] : m[a + 1]};
			end
		end
	end
endmodule

// ---- sim/hcmd_core_chk.sv ----
// port assertions for the command block
`timescale 1ns/1ps
module hcmd_core_chk (
	input wire logic        clk,
	input wire logic        rst,
	input wire logic        mem_req,
	input wire logic        mem_ack,
	input wire logic [31:0] mem_addr,
	input wire logic [1:0]  mem_be,
	input wire logic        link_dma_hold,
	input wire logic        bus_error,
	input wire logic        tx_enable,
	input wire logic        rx_enable,
	input wire logic        timeout_enable,
	input wire logic        tx_frame_start,
	input wire logic        nonstd_frame_evt,
	input wire logic        idle_timer_start,
	input wire logic [7:0]  pad_time_sel,
	input wire logic [15:0] nonstd_ctrl,
	input wire logic [15:0] idle_link_timer
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	a_req_held: assert property (mem_req && !mem_ack |=> mem_req && $stable(mem_addr))
		else $error("dma request moved before ack");
	a_half_even: assert property (mem_req && mem_be == 2'h3 |-> !mem_addr[0])
		else $error("halfword access at odd address");
	a_hold_end: assert property ($fell(link_dma_hold) |->
		$past(mem_ack) || $past(mem_ack, 2)) else $error("dma hold ended off an ack");
	a_en_tied: assert property (tx_enable == rx_enable && rx_enable == timeout_enable)
		else $error("link enables differ");
	a_err_stops: assert property (bus_error |=> !tx_enable)
		else $error("transmit on after bus error");
	a_pad_wait: assert property (!tx_frame_start |=> $stable(pad_time_sel))
		else $error("pad time changed off a frame start");
	a_nsc_wait: assert property (!nonstd_frame_evt |=> $stable(nonstd_ctrl))
		else $error("nonstandard control changed off its frame");
	a_idle_wait: assert property (!idle_timer_start |=> $stable(idle_link_timer))
		else $error("idle timer changed off a start");
endmodule
bind hcmd_core hcmd_core_chk chk_i (.*);

// ---- sim/host_test_and_state_commands_tb_top.sv ----
// bench for the host test and state command block
`timescale 1ns/1ps
module host_test_and_state_commands_tb_top import hcmd_pkg::*;;
	logic clk = 1'h0, rst = 1'h1, bus_error = 1'h0, filter_mode = 1'h0;
	logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
	logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
	logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0, pad_time_sel;
	logic [2:0] s_axi_awprot = '0, s_axi_arprot = '0, ev = '0;
	logic [3:0] s_axi_wstrb = 4'hf;
	logic [31:0] s_axi_wdata = '0, s_axi_rdata, mem_addr, d;
	logic [1:0] s_axi_bresp, s_axi_rresp, mem_be, resp, lat = '0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic mem_req, mem_we, mem_ack, tx_enable, rx_enable, timeout_enable, link_dma_hold;
	logic [15:0] mem_wdata, mem_rdata, nonstd_ctrl, idle_link_timer, filter_mask_w2 = '0;
	logic [15:0] rx_k_or_mask1 = 16'hcafe, rx_ack_var = 16'h1234;
	wire tx_frame_start = ev[0], nonstd_frame_evt = ev[1], idle_timer_start = ev[2];
	int miscompares = 0, n_checks = 0, cyc = 0;
	hcmd_core dut (.*);
	hcmd_mem mem (.clk(clk), .req(mem_req), .we(mem_we), .addr(mem_addr), .wdata(mem_wdata),
		.be(mem_be), .lat(lat), .ack(mem_ack), .rdata(mem_rdata));
	initial forever #5 clk = ~clk;
	task automatic stop_test;
		$display("checks %0d mismatches %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	always @(posedge clk) begin
		if (++cyc == 20000) begin
			miscompares++;
			stop_test;
		end
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			$display("wrong value at %0t got %h exp %h", $time, got, exp);
			miscompares++;
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		do begin
			@(posedge clk);
			if (s_axi_awready) s_axi_awvalid <= 1'h0;
			if (s_axi_wready) s_axi_wvalid <= 1'h0;
		end while (!s_axi_bvalid);
		s_axi_bready <= 1'h0;
		resp = s_axi_bresp;
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] v);
		@(posedge clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		do begin
			@(posedge clk);
			if (s_axi_arready) s_axi_arvalid <= 1'h0;
		end while (!s_axi_rvalid);
		s_axi_rready <= 1'h0;
		v = s_axi_rdata;
		resp = s_axi_rresp;
	endtask
	task automatic put32(input int a, input logic [31:0] v);
		for (int i = 0; i < 4; i++) mem.m[a + i] = v[31 - 8 * i -: 8];
	endtask
	function automatic logic [31:0] get32(input int a);
		return {mem.m[a], mem.m[a + 1], mem.m[a + 2], mem.m[a + 3]};
	endfunction
	task automatic cmd(input logic [7:0] c, input logic busy);
		rd(REG_SEM, d);
		wr(REG_CMD, {24'h0, c});
		rd(REG_SEM, d);
		if (busy) chk(d, 32'hfe);
		if (busy) chk(link_dma_hold, c == OP_COPY);
		do rd(REG_SEM, d); while (d !== 32'hff);
	endtask
	task automatic t_copy(input logic b16, input int n, input int s, input int t);
		wr(REG_CFG, {31'h0, b16});
		put32(11'h110, n);
		put32(11'h114, s);
		put32(11'h118, t);
		for (int i = 0; i < 8; i++) mem.m[s + i] = 8'(i * 29 + 7);
		for (int i = 0; i < 8; i++) mem.m[t + i] = 8'hee;
		cmd(OP_COPY, 1'h1);
		for (int i = 0; i < 8; i++) chk(mem.m[t + i], i < n ? mem.m[s + i] : 8'hee);
		chk(link_dma_hold, 1'h0);
	endtask
	task automatic t_dump;
		wr(REG_TXNEXT, 32'h11223344);
		wr(REG_TXLLT, 32'h55667788);
		put32(11'h114, 32'h500);
		for (int f = 0; f < 2; f++) begin
			filter_mode <= f[0];
			filter_mask_w2 <= f[0] ? 16'hbeef : '0;
			for (int i = 0; i < 660; i++) mem.m[11'h500 + i] = 8'h5a;
			cmd(OP_DUMP, 1'h1);
			chk(get32(11'h5f2), {16'hcafe, f[0] ? 16'hbeef : rx_ack_var});
			chk(get32(11'h5fc), 32'h1);
			chk(get32(11'h614), 32'h11223344);
			chk(get32(11'h618), 32'h55667788);
			chk({mem.m[11'h789], mem.m[11'h78a]}, 16'h5a);
		end
	endtask
	task automatic t_state;
		cmd(OP_ONLINE, 1'h0);
		chk(tx_enable, 1'h1);
		@(posedge clk) bus_error <= 1'h1;
		@(posedge clk) bus_error <= 1'h0;
		@(posedge clk);
		chk(rx_enable, 1'h0);
		mem.m[11'h5fe] = 8'h77;
		cmd(OP_DUMP, 1'h0);
		chk(mem.m[11'h5fe], 8'h77);
		cmd(OP_OFFLINE, 1'h0);
		cmd(OP_ONLINE, 1'h0);
		chk(rx_enable, 1'h1);
		cmd(OP_OFFLINE, 1'h0);
		chk(timeout_enable, 1'h0);
	endtask
	task automatic pulse(input int i);
		@(posedge clk);
		ev <= 3'h1 << i;
		@(posedge clk);
		ev <= '0;
		@(posedge clk);
	endtask
	task automatic t_reload;
		mem.m[11'h140] = 8'h3c;
		put32(11'h141, 32'h1234abcd);
		cmd(OP_ONLINE, 1'h0);
		cmd(OP_RELOAD, 1'h0);
		repeat (40) @(posedge clk);
		chk(pad_time_sel, 8'h0);
		pulse(0);
		chk(pad_time_sel, 8'h3c);
		chk(nonstd_ctrl, 16'h0);
		pulse(1);
		chk(nonstd_ctrl, 16'h1234);
		pulse(2);
		chk(idle_link_timer, 16'habcd);
	endtask
	initial begin
		repeat (2) @(posedge clk);
		rst <= 1'h0;
		rd(REG_SEM, d);
		chk(d, 32'hff);
		rd(8'h20, d);
		chk(resp, RESP_SLVERR);
		wr(8'h20, 32'h0);
		chk(resp, RESP_SLVERR);
		wr(REG_GCB, 32'h100);
		lat <= 2'h2;
		t_copy(1'h1, 5, 11'h200, 11'h300);
		t_copy(1'h0, 3, 11'h201, 11'h283);
		t_copy(1'h1, 0, 11'h220, 11'h2c0);
		lat <= '0;
		t_dump;
		t_state;
		t_reload;
		stop_test;
	end
endmodule
